//--- verilog/flash_regs.vh
// Constants for the serial flash instruction sequencer
`ifndef FLASH_REGS_VH
`define FLASH_REGS_VH

// Instruction codes
`define OP_FAST_READ    8'h0b
`define OP_PAGE_WRITE   8'h02
`define OP_SECTOR_CLEAR 8'hd8
`define OP_ARRAY_CLEAR  8'hc7
`define OP_SLEEP_ENTRY  8'hb9
`define OP_WAKE_SIG     8'hab
`define OP_READ_STATUS  8'h05
`define OP_WRITE_UNLOCK 8'h06

// Array geometry
`define ADDR_BITS       20
`define PAGE_BITS       8
`define SECTOR_BITS     16

// Status byte field positions
`define ST_BUSY         0
`define ST_WEL          1
`define ST_PROT_LO      2

// Clock rate and self-timed durations
`define CLK_MHZ                 20
`define PAGE_WRITE_TIME_US      1000
`define SECTOR_CLEAR_TIME_US    100000
`define ARRAY_CLEAR_TIME_US     1000000
`define SLEEP_ENTRY_DELAY_US    3

// Signature byte, value arbitrary
`define SIGNATURE_DEFAULT       8'h5a

`endif

//--- verilog/pin_sync.v
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 3
) (
  input  wire             clock,
  input  wire             srst,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta_reg;

  // Reset to idle-high so a held-high select shows no edge
  always @(posedge clock) begin
    if (srst) begin
      meta_reg <= {WIDTH{1'b1}};
      dout     <= {WIDTH{1'b1}};
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule // pin_sync

//--- verilog/flash_sequencer.v
// Serial flash read, program, erase and deep sleep sequencer
// Summary of operation
// - Fast read: opcode, 24-bit address, dummy byte
// - Read data shifts out on falling clock
// - Read address increments, wraps to zero
// - Select high ends read at any bit
// - Fast read rejected while cycle is busy
// - Top four address bits are ignored
// - Writes need write unlock latch set first
// - Page write: opcode, address, data bytes
// - Page write data wraps within page
// - Only last 256 bytes are programmed
// - Unsent page bytes stay untouched
// - Page write needs byte-aligned select rise
// - Busy flag high during self-timed cycle
// - Status stays readable while busy
// - Write unlock latch cleared during cycle
// - Protected page refuses page write
// - Sector clear sets whole sector to ones
// - Sector clear exact length, not protected
// - Whole clear only with zero protect level
// - Single-byte commands need exact length
// - Deep sleep after delay, wake only
// - Idle deselected is standby, reset standby
// - Deep sleep entry rejected while busy
// - Wake instruction leaves deep sleep
`timescale 1ns/1ps
`include "flash_regs.vh"
module flash_sequencer #(
  parameter        ADDR_BITS   = `ADDR_BITS,
  parameter        SECTOR_BITS = `SECTOR_BITS,
  parameter [31:0] PAGE_CYC    = `PAGE_WRITE_TIME_US * `CLK_MHZ,
  parameter [31:0] SECTOR_CYC  = `SECTOR_CLEAR_TIME_US * `CLK_MHZ,
  parameter [31:0] ARRAY_CYC   = `ARRAY_CLEAR_TIME_US * `CLK_MHZ,
  parameter [31:0] SLEEP_CYC   = `SLEEP_ENTRY_DELAY_US * `CLK_MHZ,
  parameter [7:0]  SIGNATURE   = `SIGNATURE_DEFAULT
) (
  input  wire       clock,
  input  wire       srst,
  input  wire       cs_n_pin,
  input  wire       sck_pin,
  input  wire       si_pin,
  input  wire [2:0] protect_level,
  output reg        so_out,
  output reg        so_oe,
  output reg        busy_flag,
  output reg        write_unlock_latch,
  output reg        deep_sleep,
  output wire       standby
);

  localparam NS = ADDR_BITS - SECTOR_BITS;

  localparam [2:0] PH_CMD    = 3'd0;
  localparam [2:0] PH_ADDR   = 3'd1;
  localparam [2:0] PH_DUMMY  = 3'd2;
  localparam [2:0] PH_READ   = 3'd3;
  localparam [2:0] PH_WDATA  = 3'd4;
  localparam [2:0] PH_STAT   = 3'd5;
  localparam [2:0] PH_SIG    = 3'd6;
  localparam [2:0] PH_IGNORE = 3'd7;

  localparam [1:0] OP_PAGE   = 2'd0;
  localparam [1:0] OP_SECTOR = 2'd1;
  localparam [1:0] OP_BULK   = 2'd2;

  reg [7:0] mem [0:(1<<ADDR_BITS)-1];
  reg [7:0] page_buf [0:255];

  wire [2:0] pins_s;
  wire       cs_n_s = pins_s[2];
  wire       sck_s  = pins_s[1];
  wire       si_s   = pins_s[0];

  reg                 sck_prev_reg;
  reg                 cs_prev_reg;
  reg [2:0]           phase_reg;
  reg [7:0]           opcode_reg;
  reg [6:0]           rx_reg;
  reg [2:0]           bit_cnt_reg;
  reg [2:0]           nbytes_reg;
  reg [1:0]           abyte_reg;
  reg [ADDR_BITS-1:0] addr_reg;
  reg [7:0]           tx_reg;
  reg [7:0]           col_reg;
  reg [255:0]         page_mask_reg;
  reg [1:0]           op_reg;
  reg [31:0]          timer_reg;
  reg [ADDR_BITS-1:0] walk_reg;
  reg [ADDR_BITS-1:0] walk_end_reg;
  reg                 walk_done_reg;
  reg                 sleep_pend_reg;
  reg [31:0]          sleep_cnt_reg;
  integer             i;

  wire       sck_rise = sck_s & ~sck_prev_reg;
  wire       sck_fall = ~sck_s & sck_prev_reg;
  wire       cs_rise  = cs_n_s & ~cs_prev_reg;
  wire       sel      = ~cs_n_s;
  wire [7:0] byte_v   = {rx_reg, si_s};
  wire       byte_end = sel & sck_rise & (bit_cnt_reg == 3'd7);
  wire       asleep   = deep_sleep | sleep_pend_reg;
  wire       aligned  = (bit_cnt_reg == 3'd0);
  wire       normal   = ~busy_flag & ~asleep & aligned;
  wire       out_ph   = (phase_reg == PH_READ) | (phase_reg == PH_STAT) | (phase_reg == PH_SIG);
  wire [ADDR_BITS-1:0] next_addr = {addr_reg[ADDR_BITS-9:0], byte_v};
  wire [7:0] status_byte;

  assign status_byte[`ST_BUSY]          = busy_flag;
  assign status_byte[`ST_WEL]           = write_unlock_latch;
  assign status_byte[`ST_PROT_LO+2:`ST_PROT_LO] = protect_level;
  assign status_byte[7:`ST_PROT_LO+3]   = 3'b000;

  // Protects the top 2^(level-1) sectors; large levels protect all
  function prot_hit;
    input [ADDR_BITS-1:0] a;
    input [2:0]           lvl;
    reg   [NS-1:0]        low;
    begin
      low      = ~({NS{1'b1}} << (lvl - 3'd1));
      prot_hit = (lvl != 3'd0) && ((a[ADDR_BITS-1:SECTOR_BITS] | low) == {NS{1'b1}});
    end
  endfunction

  wire do_unlock = cs_rise & normal & (opcode_reg == `OP_WRITE_UNLOCK) & (nbytes_reg == 3'd1);
  wire do_page   = cs_rise & normal & write_unlock_latch & (opcode_reg == `OP_PAGE_WRITE)
                   & (phase_reg == PH_WDATA) & (nbytes_reg >= 3'd5)
                   & ~prot_hit(addr_reg, protect_level);
  wire do_sector = cs_rise & normal & write_unlock_latch & (opcode_reg == `OP_SECTOR_CLEAR)
                   & (nbytes_reg == 3'd4)
                   & ~prot_hit(addr_reg, protect_level);
  wire do_bulk   = cs_rise & normal & write_unlock_latch & (opcode_reg == `OP_ARRAY_CLEAR)
                   & (nbytes_reg == 3'd1) & (protect_level == 3'd0);
  wire do_sleep  = cs_rise & normal & (opcode_reg == `OP_SLEEP_ENTRY)
                   & (nbytes_reg == 3'd1);
  wire do_wake   = cs_rise & ~busy_flag & asleep & (opcode_reg == `OP_WAKE_SIG)
                   & (nbytes_reg != 3'd0);

  // Idle standby; power-on reset lands here, not in deep sleep
  assign standby = cs_n_s & ~busy_flag & ~asleep;

  pin_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clock (clock),
    .srst  (srst),
    .din   ({cs_n_pin, sck_pin, si_pin}),
    .dout  (pins_s)
  );

  // Erased at start; synthesis may map this to array init
  initial begin
    for (i = 0; i < (1 << ADDR_BITS); i = i + 1)
      mem[i] = 8'hff;
  end

  // Serial front end: bits in on rising, out on falling
  always @(posedge clock) begin
    if (srst) begin
      sck_prev_reg  <= 1'b1;
      cs_prev_reg   <= 1'b1;
      phase_reg     <= PH_CMD;
      opcode_reg    <= 8'h00;
      rx_reg        <= 7'h00;
      bit_cnt_reg   <= 3'd0;
      nbytes_reg    <= 3'd0;
      abyte_reg     <= 2'd0;
      addr_reg      <= {ADDR_BITS{1'b0}};
      tx_reg        <= 8'h00;
      col_reg       <= 8'h00;
      page_mask_reg <= 256'h0;
      so_out        <= 1'b0;
      so_oe         <= 1'b0;
    end else begin
      sck_prev_reg <= sck_s;
      cs_prev_reg  <= cs_n_s;
      if (cs_n_s) begin
        // Deselect aborts mid-byte; partial bits are dropped
        phase_reg   <= PH_CMD;
        bit_cnt_reg <= 3'd0;
        abyte_reg   <= 2'd0;
        so_oe       <= 1'b0;
        if (cs_rise)
          nbytes_reg <= 3'd0;
      end else if (sck_rise) begin
        rx_reg      <= byte_v[6:0];
        bit_cnt_reg <= bit_cnt_reg + 3'd1;
        if (byte_end) begin
          if (nbytes_reg != 3'd7)
            nbytes_reg <= nbytes_reg + 3'd1;
          case (phase_reg)
            PH_CMD: begin
              opcode_reg <= byte_v;
              abyte_reg  <= 2'd0;
              if (asleep) begin
                // Only the wake instruction is decoded in deep sleep
                phase_reg <= (byte_v == `OP_WAKE_SIG) ? PH_ADDR : PH_IGNORE;
              end else if (busy_flag) begin
                phase_reg <= (byte_v == `OP_READ_STATUS) ? PH_STAT : PH_IGNORE;
                tx_reg    <= status_byte;
              end else begin
                case (byte_v)
                  `OP_FAST_READ, `OP_SECTOR_CLEAR, `OP_WAKE_SIG: phase_reg <= PH_ADDR;
                  `OP_PAGE_WRITE: begin
                    phase_reg     <= PH_ADDR;
                    page_mask_reg <= 256'h0;
                  end
                  `OP_READ_STATUS: begin
                    phase_reg <= PH_STAT;
                    tx_reg    <= status_byte;
                  end
                  default: phase_reg <= PH_IGNORE;
                endcase
              end
            end
            PH_ADDR: begin
              abyte_reg <= abyte_reg + 2'd1;
              if (opcode_reg != `OP_WAKE_SIG)
                addr_reg <= next_addr;
              if (abyte_reg == 2'd2) begin
                case (opcode_reg)
                  `OP_FAST_READ:  phase_reg <= PH_DUMMY;
                  `OP_PAGE_WRITE: begin
                    phase_reg <= PH_WDATA;
                    col_reg   <= byte_v;
                  end
                  `OP_WAKE_SIG: begin
                    phase_reg <= PH_SIG;
                    tx_reg    <= SIGNATURE;
                  end
                  default: phase_reg <= PH_IGNORE;
                endcase
              end
            end
            PH_DUMMY, PH_READ: begin
              phase_reg <= PH_READ;
              tx_reg    <= mem[addr_reg];
              addr_reg  <= addr_reg + 1'b1;
            end
            PH_WDATA: begin
              // Later bytes overwrite earlier ones at the same column
              page_buf[col_reg]      <= byte_v;
              page_mask_reg[col_reg] <= 1'b1;
              col_reg                <= col_reg + 8'd1;
            end
            PH_STAT: tx_reg <= status_byte;
            PH_SIG:  tx_reg <= SIGNATURE;
            default: phase_reg <= PH_IGNORE;
          endcase
        end
      end else if (sck_fall && out_ph) begin
        so_out <= tx_reg[7];
        so_oe  <= 1'b1;
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // Self-timed cycles, write unlock latch and deep sleep
  always @(posedge clock) begin
    if (srst) begin
      busy_flag          <= 1'b0;
      write_unlock_latch <= 1'b0;
      deep_sleep         <= 1'b0;
      sleep_pend_reg     <= 1'b0;
      sleep_cnt_reg      <= 32'd0;
      op_reg             <= OP_PAGE;
      timer_reg          <= 32'd0;
      walk_reg           <= {ADDR_BITS{1'b0}};
      walk_end_reg       <= {ADDR_BITS{1'b0}};
      walk_done_reg      <= 1'b1;
    end else begin
      if (do_unlock)
        write_unlock_latch <= 1'b1;
      if (do_page | do_sector | do_bulk) begin
        busy_flag          <= 1'b1;
        write_unlock_latch <= 1'b0;
        walk_done_reg      <= 1'b0;
        if (do_page) begin
          op_reg       <= OP_PAGE;
          timer_reg    <= PAGE_CYC;
          walk_reg     <= {ADDR_BITS{1'b0}};
          walk_end_reg <= {{(ADDR_BITS-8){1'b0}}, 8'hff};
        end else if (do_sector) begin
          op_reg       <= OP_SECTOR;
          timer_reg    <= SECTOR_CYC;
          walk_reg     <= {addr_reg[ADDR_BITS-1:SECTOR_BITS], {SECTOR_BITS{1'b0}}};
          walk_end_reg <= {addr_reg[ADDR_BITS-1:SECTOR_BITS], {SECTOR_BITS{1'b1}}};
        end else begin
          op_reg       <= OP_BULK;
          timer_reg    <= ARRAY_CYC;
          walk_reg     <= {ADDR_BITS{1'b0}};
          walk_end_reg <= {ADDR_BITS{1'b1}};
        end
      end else if (busy_flag) begin
        // Array walk is one byte a cycle; busy covers both timer and walk
        if (timer_reg != 32'd0)
          timer_reg <= timer_reg - 32'd1;
        if (!walk_done_reg) begin
          case (op_reg)
            OP_PAGE: begin
              if (page_mask_reg[walk_reg[7:0]])
                mem[{addr_reg[ADDR_BITS-1:8], walk_reg[7:0]}] <=
                  mem[{addr_reg[ADDR_BITS-1:8], walk_reg[7:0]}] & page_buf[walk_reg[7:0]];
            end
            default: mem[walk_reg] <= 8'hff;
          endcase
          if (walk_reg == walk_end_reg)
            walk_done_reg <= 1'b1;
          else
            walk_reg <= walk_reg + 1'b1;
        end else if (timer_reg == 32'd0) begin
          busy_flag <= 1'b0;
        end
      end
      if (do_sleep) begin
        sleep_pend_reg <= 1'b1;
        sleep_cnt_reg  <= SLEEP_CYC;
      end else if (do_wake) begin
        sleep_pend_reg <= 1'b0;
        deep_sleep     <= 1'b0;
      end else if (sleep_pend_reg) begin
        if (sleep_cnt_reg <= 32'd1) begin
          sleep_pend_reg <= 1'b0;
          deep_sleep     <= 1'b1;
        end else begin
          sleep_cnt_reg <= sleep_cnt_reg - 32'd1;
        end
      end
    end
  end

endmodule // flash_sequencer

//--- test/flash_sequencer_sva.sv
// Port assertions for the flash sequencer
`timescale 1ns/1ps
module flash_sequencer_sva (
  input wire       clock,
  input wire       srst,
  input wire       cs_n_pin,
  input wire       sck_pin,
  input wire       si_pin,
  input wire [2:0] protect_level,
  input wire       so_out,
  input wire       so_oe,
  input wire       busy_flag,
  input wire       write_unlock_latch,
  input wire       deep_sleep,
  input wire       standby
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  reset_idle_a: assert property ($fell(srst) |-> !busy_flag && !deep_sleep && !so_oe)
    else $error("outputs not idle after reset");
  standby_idle_a: assert property (standby |->
    !busy_flag && !deep_sleep && $past(cs_n_pin, 2))
    else $error("standby while busy or asleep");
  sleep_not_busy_a: assert property (deep_sleep |-> !busy_flag)
    else $error("asleep during a cycle");
  busy_needs_latch_a: assert property ($rose(busy_flag) |-> $past(write_unlock_latch))
    else $error("cycle started without unlock");
  busy_no_latch_a: assert property (busy_flag |-> !write_unlock_latch)
    else $error("unlock latch set during cycle");
  busy_on_deselect_a: assert property ($rose(busy_flag) |-> cs_n_pin && $past(cs_n_pin, 2))
    else $error("cycle started while selected");
  busy_hold_a: assert property ($rose(busy_flag) |=> busy_flag [*8])
    else $error("cycle too short");
  oe_release_a: assert property (cs_n_pin [*5] |-> !so_oe)
    else $error("output driven while deselected");
  so_on_low_a: assert property (!$stable(so_out) |-> !sck_pin)
    else $error("output changed with serial clock high");
  sleep_on_deselect_a: assert property ($rose(deep_sleep) |-> cs_n_pin)
    else $error("sleep entered while selected");
  wake_on_deselect_a: assert property ($fell(deep_sleep) |-> cs_n_pin)
    else $error("wake while selected");
endmodule // flash_sequencer_sva

bind flash_sequencer flash_sequencer_sva u_sva (
  .clock(clock), .srst(srst), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .si_pin(si_pin),
  .protect_level(protect_level), .so_out(so_out), .so_oe(so_oe), .busy_flag(busy_flag),
  .write_unlock_latch(write_unlock_latch), .deep_sleep(deep_sleep), .standby(standby));

//--- test/spi_master_model.sv
// Behavioural serial bus master, mode 0, clock idle low
`timescale 1ns/1ps
module spi_master_model (
  input  wire clock,
  input  wire so,
  output reg  cs_n,
  output reg  sck,
  output reg  si
);
  localparam HALF = 200;

  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  task sel;
    begin
      @(posedge clock);
      #1 cs_n = 1'b0;
      #HALF;
    end
  endtask

  // Short counts let a frame end mid-byte
  task xbits(input [7:0] tx, input integer n, output [7:0] rx);
    integer i;
    begin
      rx = 8'h00;
      for (i = 7; i > 7 - n; i = i - 1) begin
        si = tx[i];
        #HALF sck = 1'b1;
        rx = {rx[6:0], so};
        #HALF sck = 1'b0;
      end
    end
  endtask

  // Gap sets a prompt or slow next select
  task desel(input integer gap);
    begin
      #HALF cs_n = 1'b1;
      si = ~si;
      repeat (gap) @(posedge clock);
      #1;
    end
  endtask
endmodule // spi_master_model

//--- test/flash_sequencer_test.sv
// Testbench for the flash sequencer
`timescale 1ns/1ps
`include "flash_regs.vh"
module flash_sequencer_test;
  reg         clock;
  reg         srst;
  reg  [2:0]  protect_level;
  wire        cs_n_pin;
  wire        sck_pin;
  wire        si_pin;
  wire        so_out;
  wire        so_oe;
  wire        busy_flag;
  wire        write_unlock_latch;
  wire        deep_sleep;
  wire        standby;
  wire        so_line;
  integer     err_count;
  integer     check_count;
  integer     i;
  reg  [7:0]  rx;
  reg  [23:0] got;
  reg         oe;
  reg  [10:0] rows [0:7];

  // Released line reads inverted so stray samples show up
  assign so_line = so_oe ? so_out : ~so_out;

  flash_sequencer #(.PAGE_CYC(2000), .SECTOR_CYC(10), .ARRAY_CYC(10), .SLEEP_CYC(5)) u_dut (
    .clock(clock), .srst(srst), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin), .si_pin(si_pin),
    .protect_level(protect_level), .so_out(so_out), .so_oe(so_oe), .busy_flag(busy_flag),
    .write_unlock_latch(write_unlock_latch), .deep_sleep(deep_sleep), .standby(standby));
  spi_master_model u_master (
    .clock(clock), .so(so_line), .cs_n(cs_n_pin), .sck(sck_pin), .si(si_pin));

  always #25 clock = ~clock;

  task check(input [23:0] seen, input [23:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task give_verdict;
    begin
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task xb(input [7:0] tx);
    u_master.xbits(tx, 8, rx);
  endtask

  task op(input [7:0] code, input [23:0] a);
    integer k;
    begin
      u_master.sel;
      xb(code);
      for (k = 16; k >= 0; k = k - 8)
        xb(a[k+:8]);
    end
  endtask

  task cmd(input [7:0] code);
    begin
      u_master.sel;
      xb(code);
      u_master.desel(12);
    end
  endtask

  task rd3(input [23:0] a);
    integer k;
    begin
      op(`OP_FAST_READ, a);
      xb(8'h00);
      for (k = 0; k < 3; k = k + 1) begin
        xb(8'h00);
        got = {got[15:0], rx};
      end
      oe = so_oe;
      u_master.desel(8);
    end
  endtask

  task status;
    begin
      u_master.sel;
      xb(`OP_READ_STATUS);
      xb(8'h00);
      u_master.desel(8);
    end
  endtask

  // Bound covers a sector walk, not the whole-array walk
  task idle;
    integer n;
    begin
      n = 0;
      while (busy_flag !== 1'b0 && n < 80000) begin
        @(posedge clock);
        n = n + 1;
      end
      if (busy_flag !== 1'b0) begin
        $display("ERROR t=%0t busy wait ran out", $time);
        err_count = err_count + 1;
        give_verdict;
      end
    end
  endtask

  initial begin
    clock = 1'b0;
    srst = 1'b1;
    protect_level = 3'h0;
    err_count = 0;
    check_count = 0;
    got = 24'h0;
    for (i = 0; i < 8; i = i + 1)
      rows[i] = {i[2:0], 3'h0, i[2:0], 2'h0};
    repeat (4) @(posedge clock);
    #1 srst = 1'b0;
    repeat (3) @(posedge clock);
    for (i = 0; i < 8; i = i + 1) begin
      protect_level = rows[i][10:8];
      status;
      check(24'(rx), 24'(rows[i][7:0]));
    end
    protect_level = 3'h0;
    $display("status rows done");
    op(`OP_SECTOR_CLEAR, 24'h0f0000);
    u_master.desel(8);
    check(24'(busy_flag), 24'h0);
    cmd(`OP_WRITE_UNLOCK);
    check(24'(write_unlock_latch), 24'h1);
    op(`OP_PAGE_WRITE, 24'haffffe);
    xb(8'ha1);
    xb(8'hb2);
    xb(8'hc3);
    u_master.desel(8);
    check(24'(busy_flag), 24'h1);
    status;
    check(24'(rx[1:0]), 24'h1);
    rd3(24'h000000);
    check(24'(oe), 24'h0);
    cmd(`OP_SLEEP_ENTRY);
    check(24'(deep_sleep), 24'h0);
    idle;
    rd3(24'h5ffffe);
    check(got, 24'ha1b2ff);
    check(24'(oe), 24'h1);
    op(`OP_FAST_READ, 24'h000000);
    xb(8'h00);
    u_master.xbits(8'h00, 5, rx);
    u_master.desel(8);
    check(24'(so_oe), 24'h0);
    protect_level = 3'h2;
    status;
    check(24'(rx), 24'h08);
    protect_level = 3'h0;
    rd3(24'h0ffeff);
    check(got, 24'hffc3ff);
    $display("page write done");
    cmd(`OP_WRITE_UNLOCK);
    op(`OP_PAGE_WRITE, 24'h001000);
    for (i = 0; i < 258; i = i + 1)
      xb(i[7:0] | {i[8], 7'h0});
    u_master.desel(8);
    idle;
    rd3(24'h001000);
    check(got, 24'h808102);
    $display("long page done");
    protect_level = 3'h1;
    cmd(`OP_WRITE_UNLOCK);
    op(`OP_PAGE_WRITE, 24'h0f0000);
    xb(8'h00);
    u_master.desel(8);
    check(24'(busy_flag), 24'h0);
    op(`OP_SECTOR_CLEAR, 24'h0f0000);
    u_master.desel(8);
    check(24'(busy_flag), 24'h0);
    cmd(`OP_ARRAY_CLEAR);
    check(24'(busy_flag), 24'h0);
    protect_level = 3'h0;
    op(`OP_PAGE_WRITE, 24'h000000);
    xb(8'h00);
    u_master.xbits(8'h00, 3, rx);
    u_master.desel(8);
    check(24'(busy_flag), 24'h0);
    cmd(`OP_WRITE_UNLOCK);
    op(`OP_SECTOR_CLEAR, 24'h3f1234);
    u_master.desel(8);
    check(24'(busy_flag), 24'h1);
    idle;
    rd3(24'h0ffeff);
    check(got, 24'hffffff);
    $display("refusals and erase done");
    u_master.sel;
    xb(`OP_SLEEP_ENTRY);
    u_master.xbits(8'h00, 1, rx);
    u_master.desel(12);
    check(24'(deep_sleep), 24'h0);
    cmd(`OP_SLEEP_ENTRY);
    check(24'({deep_sleep, standby}), 24'h2);
    cmd(`OP_WRITE_UNLOCK);
    check(24'(write_unlock_latch), 24'h0);
    cmd(`OP_WAKE_SIG);
    check(24'({deep_sleep, standby}), 24'h1);
    $display("sleep done");
    cmd(`OP_WRITE_UNLOCK);
    cmd(`OP_ARRAY_CLEAR);
    check(24'({busy_flag, write_unlock_latch}), 24'h2);
    srst = 1'b1;
    repeat (4) @(posedge clock);
    #1 srst = 1'b0;
    @(posedge clock);
    #1;
    check(24'({write_unlock_latch, busy_flag, standby}), 24'h1);
    $display("second reset done");
    give_verdict;
  end
endmodule // flash_sequencer_test
